// >>> common/ssl_pkg.sv
// Shared constants for the strap, LED and serial pin block
package ssl_pkg;
	// ----------------------------------------
	// Clock rates and derived divisions
	// ----------------------------------------
	localparam int CLK_HZ = 125_000_000;
	localparam int LINK_HZ = 31_250_000;
	localparam int MDC_HZ = 1_000_000;
	localparam int MDC_HALF_CYC = LINK_HZ / (2 * MDC_HZ);
	localparam int AUX_HZ_STD = 25_000_000;
	localparam int AUX_HZ_SINGLE = 10_000_000;
	localparam int AUX_HZ_SLAVE = 50_000_000;
	localparam logic [4:0] AUX_DIV_STD = 5'(CLK_HZ / AUX_HZ_STD);
	localparam logic [4:0] AUX_DIV_SINGLE = 5'(CLK_HZ / AUX_HZ_SINGLE);
	localparam logic [4:0] AUX_DIV_SLAVE = 5'(CLK_HZ / AUX_HZ_SLAVE);

	// ----------------------------------------
	// Management frame layout
	// ----------------------------------------
	localparam int MDIO_HDR_BITS = 46;
	localparam int MDIO_TA_END = 48;
	localparam int MDIO_FRAME_BITS = 64;

	// ----------------------------------------
	// Register map and fields
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_PORTS = 8'h08;
	localparam int CTRL_SEL_BIT = 0;
	localparam int CTRL_CLK_BIT = 1;
	localparam int CTRL_WD_BIT = 2;
	localparam logic [2:0] CTRL_RST = 3'h0;
	localparam int STAT_AN_BIT = 0;
	localparam int STAT_XO_BIT = 1;
	localparam int STAT_DC_BIT = 2;
	localparam int STAT_RD_BIT = 3;
	localparam int STAT_HOLD_BIT = 4;
	localparam int PORTS_DPX_LSB = 16;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	// ----------------------------------------
	// Strap defaults and pin sync positions
	// ----------------------------------------
	localparam logic STRAP_AN_RST = 1'b1;
	localparam logic STRAP_XO_RST = 1'b1;
	localparam logic STRAP_DC_RST = 1'b0;
	localparam int SI_RSTN = 0;
	localparam int SI_RC = 1;
	localparam int SI_DUP0 = 2;
	localparam int SI_CK = 3;
	localparam int SI_WD = 4;
	localparam int SI_RD = 5;
	localparam int SI_CASC = 6;
	localparam int SI_SMII = 7;
endpackage

// >>> core/ssl_sync2.sv
// Two flip-flop level synchroniser
`timescale 1ns/1ps
module ssl_sync2 #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			q <= RESET_VAL;
		end else begin
			meta_reg <= d;
			q <= meta_reg;
		end
	end
endmodule

// >>> core/ssl_mdio_poll.sv
// Management clock generator and per-port status poller
`timescale 1ns/1ps
module ssl_mdio_poll
	import ssl_pkg::*;
#(
	parameter int NPORTS = 8,
	parameter logic [4:0] PHY_BASE = 5'h00,
	parameter logic [4:0] STAT_REG = 5'h00,
	parameter int SPD_BIT = 13,
	parameter int DPX_BIT = 8
) (
	input wire logic link_clk,
	input wire logic rst,
	input wire logic hold,
	input wire logic mdio_in,
	output logic mdc,
	output logic mdio_out,
	output logic mdio_oe_n,
	output logic [NPORTS-1:0] speed100,
	output logic [NPORTS-1:0] full,
	output logic tgl
);
	localparam int PW = $clog2(NPORTS);
	typedef enum {ST_IDLE, ST_RUN} ssl_mdio_state_t;

	ssl_mdio_state_t state_reg;
	logic mdio_s;
	logic [4:0] div_reg;
	logic tick, fall, rise, last;
	logic [5:0] bit_reg, bit_next;
	logic [PW-1:0] port_reg, port_next;
	logic [15:0] shift_reg;
	logic [NPORTS-1:0] work_spd_reg, work_full_reg, upd_spd, upd_full;

	function automatic logic hdr_bit(input logic [PW-1:0] p, input logic [5:0] idx);
		logic [MDIO_HDR_BITS-1:0] hdr;
		hdr = {32'hFFFF_FFFF, 2'b01, 2'b10, PHY_BASE + 5'(p), STAT_REG};
		return (idx < 6'(MDIO_HDR_BITS)) ? hdr[6'(MDIO_HDR_BITS - 1) - idx] : 1'b1;
	endfunction

	ssl_sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_mdio_sync (
		.clk(link_clk),
		.rst(rst),
		.d(mdio_in),
		.q(mdio_s)
	);

	assign tick = div_reg == 5'(MDC_HALF_CYC - 1);
	assign fall = tick && mdc;
	assign rise = tick && !mdc;
	assign last = bit_reg == 6'(MDIO_FRAME_BITS - 1);
	assign bit_next = last ? 6'h00 : bit_reg + 6'h01;
	assign port_next = !last ? port_reg :
		(port_reg == PW'(NPORTS - 1)) ? '0 : port_reg + 1'b1;

	// ----------------------------------------
	// Clock and frame sequencing
	// ----------------------------------------
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			state_reg <= ST_IDLE;
			div_reg <= 5'h00;
			mdc <= 1'b0;
			bit_reg <= 6'h00;
			port_reg <= '0;
			mdio_out <= 1'b1;
			mdio_oe_n <= 1'b1;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					div_reg <= 5'h00;
					mdc <= 1'b0;
					bit_reg <= 6'h00;
					port_reg <= '0;
					mdio_oe_n <= 1'b1;
					if (!hold) begin
						state_reg <= ST_RUN;
						mdio_out <= hdr_bit('0, 6'h00);
						mdio_oe_n <= 1'b0;
					end
				end
				ST_RUN: begin
					if (hold) begin
						state_reg <= ST_IDLE;
						mdio_oe_n <= 1'b1;
						mdc <= 1'b0;
					end else begin
						div_reg <= tick ? 5'h00 : div_reg + 5'h01;
						if (tick) begin
							mdc <= !mdc;
						end
						if (fall) begin
							bit_reg <= bit_next;
							port_reg <= port_next;
							mdio_out <= hdr_bit(port_next, bit_next);
							// Turnaround and data belong to the PHY
							mdio_oe_n <= bit_next >= 6'(MDIO_HDR_BITS);
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ----------------------------------------
	// Read data capture and publication
	// ----------------------------------------
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			shift_reg <= 16'h0000;
		end else if (state_reg == ST_RUN && rise && bit_reg >= 6'(MDIO_TA_END)) begin
			shift_reg <= {shift_reg[14:0], mdio_s};
		end
	end

	always_comb begin
		upd_spd = work_spd_reg;
		upd_full = work_full_reg;
		upd_spd[port_reg] = shift_reg[SPD_BIT];
		upd_full[port_reg] = shift_reg[DPX_BIT];
	end

	// Whole scan is published at once so the other side sees one snapshot
	always_ff @(posedge link_clk or posedge rst) begin
		if (rst) begin
			work_spd_reg <= '0;
			work_full_reg <= '0;
			speed100 <= '0;
			full <= '0;
			tgl <= 1'b0;
		end else if (state_reg == ST_RUN && !hold && fall && last) begin
			work_spd_reg <= upd_spd;
			work_full_reg <= upd_full;
			if (port_reg == PW'(NPORTS - 1)) begin
				speed100 <= upd_spd;
				full <= upd_full;
				tgl <= !tgl;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb_link @(posedge link_clk); endclocking
	default disable iff (rst);

	AST_MDIO_FLOAT: assert property (hold |=> mdio_oe_n)
		else $error("mdio driven during reset hold");
	AST_MDIO_TA: assert property (state_reg == ST_RUN && bit_reg >= 6'(MDIO_HDR_BITS)
		&& !$changed(bit_reg) |-> mdio_oe_n)
		else $error("mdio driven during read phase");
	AST_MDC_RATE: assert property (state_reg == ST_RUN && !hold && $changed(mdc)
		|-> $past(div_reg) == 5'(MDC_HALF_CYC - 1))
		else $error("mdc half period wrong");
endmodule

// >>> core/ssl_strap_pins.sv
// Strap capture, LED drive, serial pins and register slave
//
// Added by the designer: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
module ssl_strap_pins
	import ssl_pkg::*;
#(
	parameter int NPORTS = 8,
	parameter logic [4:0] PHY_BASE = 5'h00,
	parameter logic [4:0] STAT_REG = 5'h00,
	parameter int SPD_BIT = 13,
	parameter int DPX_BIT = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic reset_active_low,
	input wire logic por_rc_input,
	input wire logic cascade_slave_mode,
	input wire logic single_mii_eight_port_cfg,
	input wire logic [NPORTS-1:0] collision_event,
	input wire logic cfgmem_read_data,
	output logic cfgmem_select,
	output logic cfgmem_select_oe_n,
	input wire logic cfgmem_serial_clock_in,
	output logic cfgmem_serial_clock_out,
	output logic cfgmem_serial_clock_oe_n,
	input wire logic cfgmem_write_data_in,
	output logic cfgmem_write_data_out,
	output logic cfgmem_write_data_oe_n,
	input wire logic duplex_led0_in,
	output logic duplex_led0_out,
	output logic duplex_led0_oe_n,
	output logic [NPORTS-1:1] duplex_led,
	output logic [NPORTS-1:0] speed_led,
	output logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe_n,
	output logic aux_clock_out,
	output logic autoneg_strap,
	output logic crossover_strap,
	output logic dual_colour_strap
);
	logic [7:0] pin_s;
	logic pin_hold, hold_prev_reg, hold_release, pin_oe_n_reg, link_hold;
	logic [2:0] ctrl_reg;
	logic [NPORTS-1:0] mdio_speed100, mdio_full;
	logic mdio_tgl, tgl_s, tgl_seen_reg, stat_upd;
	logic [NPORTS-1:0] stat_speed100_reg, stat_full_reg, prev_full_reg, dled_reg;
	logic [4:0] aux_div, aux_cnt_reg;
	logic aw_full_reg, w_full_reg, wr_go;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg, rd_word;
	logic [3:0] wstrb_reg;
	logic [1:0] rd_resp;

	// ----------------------------------------
	// Pin synchronisers and reset hold
	// ----------------------------------------
	ssl_sync2 #(.WIDTH(8), .RESET_VAL(8'h00)) u_pin_sync (
		.clk(clk),
		.rst(rst),
		.d({single_mii_eight_port_cfg, cascade_slave_mode, cfgmem_read_data,
			cfgmem_write_data_in, cfgmem_serial_clock_in, duplex_led0_in,
			por_rc_input, reset_active_low}),
		.q(pin_s)
	);

	// Low RC node or low reset pin holds every shared pin released
	assign pin_hold = !pin_s[SI_RSTN] || !pin_s[SI_RC];
	assign hold_release = hold_prev_reg && !pin_hold;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_prev_reg <= 1'b1;
			pin_oe_n_reg <= 1'b1;
		end else begin
			hold_prev_reg <= pin_hold;
			pin_oe_n_reg <= pin_hold;
		end
	end

	// ----------------------------------------
	// Strap capture
	// ----------------------------------------
	// Synced strap pins lag by the same two flops as the reset pin,
	// so the values taken here are those present at the reset or RC pin rising edge that ends the hold.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			autoneg_strap <= STRAP_AN_RST;
			crossover_strap <= STRAP_XO_RST;
			dual_colour_strap <= STRAP_DC_RST;
		end else if (hold_release) begin
			autoneg_strap <= pin_s[SI_DUP0];
			crossover_strap <= pin_s[SI_CK];
			dual_colour_strap <= pin_s[SI_WD];
		end
	end

	// ----------------------------------------
	// Shared pin outputs
	// ----------------------------------------
	assign cfgmem_select = ctrl_reg[CTRL_SEL_BIT];
	assign cfgmem_select_oe_n = pin_oe_n_reg;
	assign cfgmem_serial_clock_out = ctrl_reg[CTRL_CLK_BIT];
	assign cfgmem_serial_clock_oe_n = pin_oe_n_reg;
	assign cfgmem_write_data_out = ctrl_reg[CTRL_WD_BIT];
	assign cfgmem_write_data_oe_n = pin_oe_n_reg;
	assign duplex_led0_out = dled_reg[0];
	assign duplex_led0_oe_n = pin_oe_n_reg;
	assign duplex_led = dled_reg[NPORTS-1:1];

	// ----------------------------------------
	// Management poller and status crossing
	// ----------------------------------------
	ssl_sync2 #(.WIDTH(1), .RESET_VAL(1'b1)) u_hold_sync (
		.clk(link_clk),
		.rst(rst),
		.d(pin_oe_n_reg),
		.q(link_hold)
	);

	ssl_mdio_poll #(
		.NPORTS(NPORTS),
		.PHY_BASE(PHY_BASE),
		.STAT_REG(STAT_REG),
		.SPD_BIT(SPD_BIT),
		.DPX_BIT(DPX_BIT)
	) u_poll (
		.link_clk(link_clk),
		.rst(rst),
		.hold(link_hold),
		.mdio_in(mdio_in),
		.mdc(mdc),
		.mdio_out(mdio_out),
		.mdio_oe_n(mdio_oe_n),
		.speed100(mdio_speed100),
		.full(mdio_full),
		.tgl(mdio_tgl)
	);

	ssl_sync2 #(.WIDTH(1), .RESET_VAL(1'b0)) u_tgl_sync (
		.clk(clk),
		.rst(rst),
		.d(mdio_tgl),
		.q(tgl_s)
	);

	// Snapshot stays stable for a whole scan, far longer than the toggle sync
	assign stat_upd = tgl_s ^ tgl_seen_reg;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			tgl_seen_reg <= 1'b0;
			stat_speed100_reg <= '0;
			stat_full_reg <= '0;
			speed_led <= '1;
		end else begin
			tgl_seen_reg <= tgl_s;
			if (stat_upd) begin
				stat_speed100_reg <= mdio_speed100;
				stat_full_reg <= mdio_full;
				speed_led <= ~mdio_speed100;
			end
		end
	end

	// ----------------------------------------
	// Duplex and collision LEDs
	// ----------------------------------------
	for (genvar i = 0; i < NPORTS; i++) begin : g_dled
		always_ff @(posedge clk or posedge rst) begin
			if (rst) begin
				prev_full_reg[i] <= 1'b1;
				dled_reg[i] <= 1'b0;
			end else begin
				prev_full_reg[i] <= stat_full_reg[i];
				if (stat_full_reg[i]) begin
					dled_reg[i] <= 1'b0;
				end else if (prev_full_reg[i]) begin
					dled_reg[i] <= 1'b1;
				end else if (collision_event[i]) begin
					dled_reg[i] <= !dled_reg[i];
				end
			end
		end
	end

	// ----------------------------------------
	// Auxiliary clock
	// ----------------------------------------
	// Only whole divisions of clk: 10M and 50M come out approximate
	always_comb begin
		if (pin_s[SI_SMII]) begin
			aux_div = AUX_DIV_SINGLE;
		end else if (pin_s[SI_CASC]) begin
			aux_div = AUX_DIV_SLAVE;
		end else begin
			aux_div = AUX_DIV_STD;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aux_cnt_reg <= 5'h00;
			aux_clock_out <= 1'b0;
		end else begin
			aux_cnt_reg <= (aux_cnt_reg >= aux_div - 5'h01) ? 5'h00 : aux_cnt_reg + 5'h01;
			aux_clock_out <= aux_cnt_reg < (aux_div >> 1);
		end
	end

	// ----------------------------------------
	// Register slave
	// ----------------------------------------
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_go = aw_full_reg && w_full_reg && !s_axi_bvalid;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			awaddr_reg <= 8'h00;
			wdata_reg <= 32'h0000_0000;
			wstrb_reg <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= AXI_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_reg <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_reg <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
			end
			if (wr_go) begin
				aw_full_reg <= 1'b0;
				w_full_reg <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg[7:2] <= REG_PORTS[7:2]) ? AXI_OKAY : AXI_SLVERR;
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Software drives the memory pins; they reach the pads after the hold
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTRL_RST;
		end else if (wr_go && awaddr_reg[7:2] == REG_CTRL[7:2] && wstrb_reg[0]) begin
			ctrl_reg <= wdata_reg[2:0];
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		rd_resp = AXI_OKAY;
		case (s_axi_araddr[7:2])
			REG_CTRL[7:2]: rd_word[2:0] = ctrl_reg;
			REG_STATUS[7:2]: begin
				rd_word[STAT_AN_BIT] = autoneg_strap;
				rd_word[STAT_XO_BIT] = crossover_strap;
				rd_word[STAT_DC_BIT] = dual_colour_strap;
				rd_word[STAT_RD_BIT] = pin_s[SI_RD];
				rd_word[STAT_HOLD_BIT] = pin_hold;
			end
			REG_PORTS[7:2]: begin
				rd_word[NPORTS-1:0] = stat_speed100_reg;
				rd_word[PORTS_DPX_LSB +: NPORTS] = stat_full_reg;
			end
			default: rd_resp = AXI_SLVERR;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= AXI_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= rd_resp;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb_sys @(posedge clk); endclocking
	default disable iff (rst);

	AST_DPX_FULL: assert property (stat_full_reg[1] |=> !duplex_led[1])
		else $error("duplex led not low at full duplex");
	AST_DPX_HALF: assert property (!stat_full_reg[3] && prev_full_reg[3] |=> duplex_led[3])
		else $error("duplex led not high on half duplex");
	AST_DPX_TOGGLE: assert property (collision_event[2] && !stat_full_reg[2]
		&& !prev_full_reg[2] |=> duplex_led[2] != $past(duplex_led[2]))
		else $error("duplex led did not toggle on collision");
	AST_SPEED: assert property (stat_upd |=> speed_led == ~$past(mdio_speed100))
		else $error("speed led mismatch");
	AST_STRAP_TAKE: assert property (hold_release |=> autoneg_strap == $past(pin_s[SI_DUP0])
		&& crossover_strap == $past(pin_s[SI_CK])
		&& dual_colour_strap == $past(pin_s[SI_WD]))
		else $error("strap not captured at release");
	AST_STRAP_HELD: assert property (!hold_release
		|=> $stable({autoneg_strap, crossover_strap, dual_colour_strap}))
		else $error("strap changed outside release");
	AST_SEL_FLOAT: assert property (pin_hold |=> cfgmem_select_oe_n)
		else $error("select driven in reset");
	AST_CLK_FLOAT: assert property (pin_hold |=> cfgmem_serial_clock_oe_n)
		else $error("memory clock driven in reset");
	AST_WD_FLOAT: assert property (pin_hold ##1 pin_hold |=> cfgmem_write_data_oe_n
		&& duplex_led0_oe_n)
		else $error("write data driven in reset");
	AST_POR: assert property (!pin_s[SI_RC]
		|=> cfgmem_select_oe_n && cfgmem_serial_clock_oe_n)
		else $error("rc low without hold");
	AST_AUX_MODE: assert property (pin_s[SI_SMII] |-> aux_div == AUX_DIV_SINGLE)
		else $error("aux division wrong in single mode");
	AST_AUX_WRAP: assert property ($stable(aux_div) && aux_cnt_reg == aux_div - 5'h01
		|=> aux_cnt_reg == 5'h00 ##1 aux_clock_out)
		else $error("aux period wrong");

	COV_RELEASE: cover property (hold_release);
	COV_COLLISION: cover property (collision_event[2] && !stat_full_reg[2] && !prev_full_reg[2]);
	COV_STAT: cover property (stat_upd);
endmodule

// >>> verification/ssl_phy_model.sv
// Management PHY and serial config memory model
`timescale 1ns/1ps
module ssl_phy_model (
	input wire logic mdc,
	input wire logic mdio_out,
	input wire logic mdio_oe_n,
	output logic mdio_in,
	input wire logic [7:0] spd,
	input wire logic [7:0] dpx,
	input wire logic sel,
	output logic rd
);
	int cnt = 100;
	logic [4:0] adr = 0;
	logic drv = 0, bit_v = 0, last = 0;
	logic [15:0] word;
	// Pulled-up line; a selected memory answers 0
	assign rd = !sel;
	// Released line shows the inverse of its last level
	assign mdio_in = !mdio_oe_n ? mdio_out : drv ? bit_v : !last;
	assign word = {2'b00, spd[adr[2:0]], 4'h0, dpx[adr[2:0]], 8'h00};
	always @(negedge mdio_oe_n) cnt = 0;
	always @(posedge mdc) begin
		last <= mdio_in;
		if (cnt >= 36 && cnt <= 40) adr <= {adr[3:0], mdio_in};
		cnt <= cnt + 1;
	end
	// Status word goes out MSB first after turnaround
	always @(negedge mdc) begin
		drv <= cnt >= 48 && cnt <= 63;
		bit_v <= word[63 - cnt];
	end
endmodule

// >>> verification/ssl_strap_pins_bench.sv
// Bench for the strap, LED and serial pin block
`timescale 1ns/1ps
module ssl_strap_pins_bench;
	import ssl_pkg::*;
	logic clk = 0, rst = 1, link_clk = 0;
	logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 0;
	logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
	logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic reset_active_low = 0, por_rc_input = 1, cascade_slave_mode = 0;
	logic single_mii_eight_port_cfg = 0, cfgmem_serial_clock_in = 0;
	logic cfgmem_write_data_in = 0, duplex_led0_in = 0;
	logic [7:0] collision_event = 0, speed_led, spd, dpx;
	logic cfgmem_read_data, cfgmem_select, cfgmem_select_oe_n, cfgmem_serial_clock_out;
	logic cfgmem_serial_clock_oe_n, cfgmem_write_data_out, cfgmem_write_data_oe_n;
	logic duplex_led0_out, duplex_led0_oe_n, mdc, mdio_in, mdio_out, mdio_oe_n;
	logic aux_clock_out, autoneg_strap, crossover_strap, dual_colour_strap;
	logic [7:1] duplex_led;
	logic [2:0] s;
	logic [33:0] rq[$];
	int err_count = 0, tests_run = 0, n;
	ssl_strap_pins i_dut (.*);
	ssl_phy_model i_phy (.mdc(mdc), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
		.mdio_in(mdio_in), .spd(spd), .dpx(dpx), .rd(cfgmem_read_data),
		.sel(cfgmem_select & !cfgmem_select_oe_n));
	initial forever #4 clk = ~clk;
	// Link clock phase kept apart from clk on purpose
	initial begin
		#3.7;
		forever #16 link_clk = ~link_clk;
	end
	// ----------------------------------------
	// Checking and bus tasks
	// ----------------------------------------
	task automatic stop_test();
		$display("checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tmo();
		err_count++;
		stop_test();
	endtask
	// Responses are compared in order as they appear
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		if (s_axi_bvalid && s_axi_bready) chk(34'(s_axi_bresp), rq.pop_front());
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] m,
		input logic [1:0] r);
		rq.push_back(34'(r));
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= m;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 0;
			if (s_axi_wready) s_axi_wvalid <= 0;
			if (s_axi_bvalid) s_axi_bready <= 0;
			if (++n > 50) tmo();
		end while (s_axi_awvalid | s_axi_wvalid | s_axi_bready);
	endtask
	task automatic rd(input logic [7:0] a, input logic [33:0] e);
		rq.push_back(e);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		n = 0;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 0;
			if (s_axi_rvalid) s_axi_rready <= 0;
			if (++n > 50) tmo();
		end while (s_axi_rready);
	endtask
	// Distance between the last two rises of sig, in ck cycles
	task automatic per(ref logic ck, ref logic sig, input int e);
		logic p;
		int a, b;
		a = -1;
		b = -1;
		p = 1;
		for (int i = 0; i < 80; i++) begin
			@(posedge ck);
			if (sig && !p) begin
				a = b;
				b = i;
			end
			p = sig;
		end
		chk(34'(b - a), 34'(e));
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		n = $urandom(41866);
		spd = 8'($urandom) | 8'h01;
		// Port 1 full and port 2 half so both LED checks see their case
		dpx = (8'($urandom) | 8'h02) & 8'hfb;
		{cfgmem_write_data_in, cfgmem_serial_clock_in, duplex_led0_in} = 3'($urandom);
		s = {cfgmem_write_data_in, cfgmem_serial_clock_in, duplex_led0_in};
		repeat (20) @(posedge clk);
		rst <= 0;
		repeat (3) @(posedge clk);
		chk({cfgmem_select_oe_n, cfgmem_serial_clock_oe_n, cfgmem_write_data_oe_n}, 7);
		chk({dual_colour_strap, crossover_strap, autoneg_strap}, 3'b011);
		reset_active_low <= 1;
		repeat (8) @(posedge clk);
		chk({dual_colour_strap, crossover_strap, autoneg_strap}, s);
		chk({cfgmem_select_oe_n, cfgmem_serial_clock_oe_n, duplex_led0_oe_n}, 0);
		{cfgmem_write_data_in, cfgmem_serial_clock_in, duplex_led0_in} <= ~s;
		repeat (4) @(posedge clk);
		rd(REG_STATUS, {AXI_OKAY, 27'h0, 2'b01, s});
		$display("strap test done");
		for (int v = 1; v < 8; v += 3) begin
			wr(REG_CTRL, 32'(v), 4'h1, AXI_OKAY);
			wr(REG_CTRL, 32'h0000_0000, 4'h0, AXI_OKAY);
			repeat (2) @(posedge clk);
			chk({cfgmem_write_data_out, cfgmem_serial_clock_out, cfgmem_select}, v);
			rd(REG_STATUS, {AXI_OKAY, 27'h0, 1'b0, !v[0], s});
			rd(REG_CTRL, {AXI_OKAY, 32'(v)});
		end
		wr(8'h0c, 32'h0000_0007, 4'hf, AXI_SLVERR);
		rd(8'h0c, {AXI_SLVERR, 32'h0000_0000});
		$display("register test done");
		for (int m = 0; m < 4; m++) begin
			{cascade_slave_mode, single_mii_eight_port_cfg} <= 2'(m);
			repeat (8) @(posedge clk);
			per(clk, aux_clock_out, m[0] ? 12 : m[1] ? 2 : 5);
		end
		$display("aux clock test done");
		per(link_clk, mdc, 30);
		for (n = 0; n < 80000 && speed_led !== ~spd; n++) @(posedge clk);
		if (n >= 80000) tmo();
		repeat (8) @(posedge clk);
		chk(speed_led, {~spd});
		chk({duplex_led, duplex_led0_out}, {~dpx});
		rd(REG_PORTS, {AXI_OKAY, 8'h0, dpx, 8'h0, spd});
		collision_event <= ~dpx;
		@(posedge clk);
		collision_event <= 0;
		repeat (3) @(posedge clk);
		chk({duplex_led, duplex_led0_out}, 0);
		$display("scan test done");
		por_rc_input <= 0;
		repeat (20) @(posedge clk);
		chk({cfgmem_select_oe_n, cfgmem_serial_clock_oe_n, mdio_oe_n}, 7);
		chk({dual_colour_strap, crossover_strap, autoneg_strap}, s);
		por_rc_input <= 1;
		repeat (8) @(posedge clk);
		chk({dual_colour_strap, crossover_strap, autoneg_strap}, {~s});
		$display("power-on test done");
		reset_active_low <= 0;
		repeat (20) @(posedge clk);
		chk({cfgmem_select_oe_n, cfgmem_write_data_oe_n, mdio_oe_n}, 7);
		chk({dual_colour_strap, crossover_strap, autoneg_strap}, {~s});
		$display("reset test done");
		stop_test();
	end
endmodule
